// ---- dlc_dialer.v ----
// Dialer hook, hands-free and hold-line control
`include "dlc_map.vh"
`default_nettype none
module dlc_dialer (
  input  wire       clock,
  input  wire       resetn,
  input  wire       hook_switch_in,
  input  wire       hands_free_request_in,
  input  wire       hold_request_in,
  input  wire [1:0] power_mode,
  input  wire       line_auto_enable,
  input  wire       speech_mute_release,
  input  wire       aux_line_release,
  input  wire       irq_ack,
  output reg        line_make_out,
  output reg        hands_free_out,
  output reg        hold_line_out,
  output reg        on_hook_status,
  output reg        dialer_irq,
  output reg  [7:0] dialer_irq_vector,
  output reg        speech_mute_out,
  output reg        speech_mute_oe_n,
  output reg        aux_line_break_out,
  output reg        aux_line_break_oe_n
);

  // Sampler lanes: 0 hook switch, 1 hands-free key, 2 hold key
  // Idle levels: hook up, hands-free key low, hold key high
  localparam [2:0] SMP_IDLE  = {`DLC_IDLE_HOLD, `DLC_IDLE_HANDS_FREE, `DLC_IDLE_HOOK};
  localparam       SMP_LANES = 3;

  // One-hot event select, highest priority first
  localparam [4:0] EV_NONE      = 5'h01;
  localparam [4:0] EV_HOOK_FALL = 5'h02;
  localparam [4:0] EV_HOOK_RISE = 5'h04;
  localparam [4:0] EV_HANDS     = 5'h08;
  localparam [4:0] EV_HOLD      = 5'h10;

  wire [2:0] pin_level;
  reg  [2:0] smp_s_q;
  reg  [2:0] smp_p_q;
  wire       hook_s_q;
  wire       hook_p_q;
  wire       hf_s_q;
  wire       hf_p_q;
  wire       hd_s_q;
  wire       hd_p_q;
  wire       active;
  wire       hook_rise;
  wire       hook_fall;
  wire       hf_pulse;
  wire       hd_pulse;
  wire       line_made;
  wire       hold_irq_hidden;
  reg  [4:0] event_sel;
  reg        hands_free_d;
  reg        hold_line_d;
  reg        irq_event;
  reg        irq_d;
  reg        on_hook_d;
  reg        line_make_d;
  reg        speech_mute_d;
  reg        speech_mute_oe_n_d;
  reg        aux_line_break_d;
  reg        aux_line_break_oe_n_d;
  genvar     lane;

  assign pin_level = {hold_request_in, hands_free_request_in, hook_switch_in};

  // input sampling
  // Samplers start at idle pin levels so reset release shows no edge
  // Pins are synchronous, so one stage plus a history flop suffices
  generate
    for (lane = 0; lane < SMP_LANES; lane = lane + 1) begin : g_lane
      always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          smp_s_q[lane] <= SMP_IDLE[lane];
          smp_p_q[lane] <= SMP_IDLE[lane];
        end else begin
          smp_s_q[lane] <= pin_level[lane];
          smp_p_q[lane] <= smp_s_q[lane];
        end
      end
    end
  endgenerate

  assign hook_s_q = smp_s_q[0];
  assign hook_p_q = smp_p_q[0];
  assign hf_s_q   = smp_s_q[1];
  assign hf_p_q   = smp_p_q[1];
  assign hd_s_q   = smp_s_q[2];
  assign hd_p_q   = smp_p_q[2];

  assign active    = (power_mode != `DLC_MODE_IDLE);
  assign hook_rise = hook_s_q & ~hook_p_q;
  assign hook_fall = ~hook_s_q & hook_p_q;
  // Pulse taken on its closing edge so a held key acts once
  assign hf_pulse  = ~hf_s_q & hf_p_q;
  assign hd_pulse  = hd_s_q & ~hd_p_q;
  assign line_made = line_make_out;
  assign hold_irq_hidden = on_hook_status & hold_line_out;

  // events dropped in idle
  // Coincident requests lose to the hook, so one event per cycle
  always @* begin
    event_sel = EV_NONE;
    if (!active) begin
      event_sel = EV_NONE;
    end else if (hook_fall) begin
      event_sel = EV_HOOK_FALL;
    end else if (hook_rise) begin
      event_sel = EV_HOOK_RISE;
    end else if (hf_pulse) begin
      event_sel = EV_HANDS;
    end else if (hd_pulse && line_made) begin
      event_sel = EV_HOLD;
    end else begin
      event_sel = EV_NONE;
    end
  end

  always @* begin
    hands_free_d = hands_free_out;
    hold_line_d  = hold_line_out;
    irq_event    = 1'b0;
    case (event_sel)
      EV_HOOK_FALL: begin
        hands_free_d = 1'b0;
        hold_line_d  = 1'b0;
        irq_event    = 1'b1;
      end
      EV_HOOK_RISE: begin
        irq_event = 1'b1;
      end
      EV_HANDS: begin
        hold_line_d  = 1'b0;
        hands_free_d = ~hands_free_out;
        irq_event    = 1'b1;
      end
      EV_HOLD: begin
        hands_free_d = 1'b0;
        hold_line_d  = ~hold_line_out;
        irq_event    = ~hold_irq_hidden;
      end
      default: begin
        hands_free_d = hands_free_out;
        hold_line_d  = hold_line_out;
        irq_event    = 1'b0;
      end
    endcase
  end

  // Set wins over acknowledge
  always @* begin
    irq_d = irq_event | (dialer_irq & ~irq_ack);
  end

  always @* begin
    on_hook_d = hook_s_q;
  end

  // forced make
  // Next states feed in so the line follows a toggle in the same cycle
  always @* begin
    line_make_d = 1'b0;
    if (line_auto_enable) begin
      line_make_d = ~hook_s_q | hands_free_d | hold_line_d;
    end
  end

  // software break
  // Both pins only ever pull low; release just lifts the enable
  always @* begin
    speech_mute_d         = `DLC_OD_LOW;
    speech_mute_oe_n_d    = speech_mute_release;
    aux_line_break_d      = `DLC_OD_LOW;
    aux_line_break_oe_n_d = aux_line_release;
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hands_free_out <= `DLC_RST_HANDS_FREE;
    end else begin
      hands_free_out <= hands_free_d;
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hold_line_out <= `DLC_RST_HOLD_LINE;
    end else begin
      hold_line_out <= hold_line_d;
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dialer_irq <= `DLC_RST_IRQ;
    end else begin
      dialer_irq <= irq_d;
    end
  end

  // Reset reads as on-hook, the idle hook level
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      on_hook_status <= `DLC_RST_ON_HOOK;
    end else begin
      on_hook_status <= on_hook_d;
    end
  end

  // Line broken while in reset
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      line_make_out <= `DLC_RST_LINE_MAKE;
    end else begin
      line_make_out <= line_make_d;
    end
  end

  // Fixed vector, kept in a flop so every output is registered
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dialer_irq_vector <= `DLC_IRQ_VECTOR;
    end else begin
      dialer_irq_vector <= `DLC_IRQ_VECTOR;
    end
  end

  // Open-drain data never goes high
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      speech_mute_out <= `DLC_RST_OD_DATA;
    end else begin
      speech_mute_out <= speech_mute_d;
    end
  end

  // Mute released until software pulls it
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      speech_mute_oe_n <= `DLC_RST_OE_N;
    end else begin
      speech_mute_oe_n <= speech_mute_oe_n_d;
    end
  end

  // Open-drain data never goes high
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aux_line_break_out <= `DLC_RST_OD_DATA;
    end else begin
      aux_line_break_out <= aux_line_break_d;
    end
  end

  // Aux break floats until software pulls it
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aux_line_break_oe_n <= `DLC_RST_OE_N;
    end else begin
      aux_line_break_oe_n <= aux_line_break_oe_n_d;
    end
  end

endmodule // dlc_dialer
`default_nettype wire

// ---- dlc_map.vh ----
// Constants for the dialer line control block
`ifndef DLC_MAP_VH
`define DLC_MAP_VH
`define DLC_IRQ_VECTOR     8'h18
`define DLC_RST_HANDS_FREE 1'b0
`define DLC_RST_HOLD_LINE  1'b0
`define DLC_RST_IRQ        1'b0
`define DLC_RST_ON_HOOK    1'b1
`define DLC_RST_LINE_MAKE  1'b0
`define DLC_RST_OD_DATA    1'b0
`define DLC_RST_OE_N       1'b1
`define DLC_OD_LOW         1'b0
`define DLC_IDLE_HOOK      1'b1
`define DLC_IDLE_HANDS_FREE 1'b0
`define DLC_IDLE_HOLD      1'b1
`define DLC_MODE_NORMAL    2'h0
`define DLC_MODE_GREEN     2'h1
`define DLC_MODE_SLEEP     2'h2
`define DLC_MODE_IDLE      2'h3
`endif

// ---- dlc_keys.sv ----
// Hook switch and key model
`default_nettype none
module dlc_keys (
  input  wire logic [1:0] key,
  input  wire logic       hook,
  output logic            hook_switch_in,
  output logic            hands_free_request_in,
  output logic            hold_request_in
);
  assign {hook_switch_in, hands_free_request_in, hold_request_in} =
    {hook, key == 2'h1, key != 2'h2};
endmodule // dlc_keys
`default_nettype wire

// ---- dlc_checker.sv ----
// Dialer line control checker
`include "dlc_map.vh"
`default_nettype none
module dlc_checker (
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic [1:0] power_mode,
  input wire logic       line_auto_enable,
  input wire logic       irq_ack,
  input wire logic       line_make_out,
  input wire logic       hands_free_out,
  input wire logic       hold_line_out,
  input wire logic       on_hook_status,
  input wire logic       dialer_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  line_off_a: assert property (!$past(line_auto_enable) |-> !line_make_out)
    else $error("line made with auto control off");
  line_forced_a: assert property ($past(line_auto_enable) && (hands_free_out || hold_line_out)
    |-> line_make_out) else $error("line not forced by active state");
  one_state_a: assert property (!(hands_free_out && hold_line_out)) else $error("both");
  hf_irq_a: assert property ($rose(hands_free_out) |-> dialer_irq) else $error("hf");
  hd_irq_a: assert property ($rose(hold_line_out) |-> dialer_irq) else $error("hd");
  hd_made_a: assert property ($rose(hold_line_out) |-> $past(line_make_out)) else $error("made");
  irq_ack_a: assert property ($fell(dialer_irq) |-> $past(irq_ack)) else $error("ack");
  off_hook_a: assert property ($fell(on_hook_status) && $past(power_mode) != `DLC_MODE_IDLE
    |-> !(hands_free_out || hold_line_out)) else $error("states kept at off-hook");
endmodule // dlc_checker
bind dlc_dialer dlc_checker dlc_checker_i (.*);
`default_nettype wire

// ---- dlc_dialer_tb_top.sv ----
// Bench for the dialer line control block
`include "dlc_map.vh"
`default_nettype none
module dlc_dialer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, resetn = 0, hook = 1, irq_ack = 0, hf = 0, hd = 0, oh = 1, ei;
  logic line_auto_enable = 1, speech_mute_release = 1, aux_line_release = 1;
  logic [1:0] key = 0, power_mode = `DLC_MODE_NORMAL;
  wire hook_switch_in, hands_free_request_in, hold_request_in, line_make_out, hands_free_out;
  wire hold_line_out, on_hook_status, dialer_irq, speech_mute_out, speech_mute_oe_n;
  wire aux_line_break_out, aux_line_break_oe_n;
  wire [7:0] dialer_irq_vector;
  int seed = 32'h9E8017AE, mismatches = 0, checks_done = 0;
  dlc_keys dlc_keys_i (.*);
  dlc_dialer dlc_dialer_i (.*);
  initial forever #50 clock = ~clock;
  function automatic logic line_exp(input logic auto_on, on_hook, hf_on, hd_on);
    return auto_on & (!on_hook | hf_on | hd_on);
  endfunction
  task chk(input logic [16:0] s, e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %0t %h %h", $time, s, e);
    end
  endtask
  // Key 3 toggles the hook; each op is acked so the next one starts clean
  task op(input logic [1:0] k);
    ei = k != 2'h0 && power_mode != `DLC_MODE_IDLE;
    ei = ei && (k != 2'h2 || line_exp(line_auto_enable, oh, hf, hd));
    if (ei && k == 2'h3) {oh, hf, hd} = {!oh, oh ? 2'h0 : {hf, hd}};
    if (ei && k == 2'h1) {hf, hd} = {!hf, 1'b0};
    if (ei && k == 2'h2) {ei, hf, hd} = {!(oh && hd), 1'b0, !hd};
    @(negedge clock);
    hook ^= k == 2'h3;
    key = k;
    repeat (2) @(negedge clock);
    key = 2'h0;
    repeat (4) @(negedge clock);
    chk({hands_free_out, hold_line_out, line_make_out, dialer_irq, on_hook_status,
      speech_mute_oe_n, aux_line_break_oe_n, speech_mute_out, aux_line_break_out,
      dialer_irq_vector}, {hf, hd, line_exp(line_auto_enable, oh, hf, hd), ei, oh,
      speech_mute_release, aux_line_release, `DLC_OD_LOW, `DLC_OD_LOW, `DLC_IRQ_VECTOR});
    irq_ack = 1;
    @(negedge clock) irq_ack = 0;
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clock);
    resetn = 1;
    op(2'h0);
    op(2'h1);
    op(2'h2);
    op(2'h2);
    power_mode = `DLC_MODE_IDLE;
    op(2'h1);
    power_mode = `DLC_MODE_GREEN;
    repeat (80) begin
      {line_auto_enable, speech_mute_release, aux_line_release} = 3'($random(seed));
      power_mode = 2'($unsigned($random(seed)) % 3);
      op(2'($random(seed)));
    end
    print_verdict;
  end
endmodule // dlc_dialer_tb_top
`default_nettype wire
